// >>> rtl/ptm_map.vh
// Notes on behaviour
// R1 - capture_source_sel 0 picks internal_capture_input, 1 the pin.
// R2 - With clear_select set, a comparator A match clears the counter.
// R3 - With clear_select low, a P match or an overflow clears the counter.
// R4 - With clear_select low, overflow clears only when period_value is zero, else the P match.
// R5 - clear_select has no effect in PWM or capture modes.
// R6 - The counter reads as count_low and count_high, read-only, reset 0.
// R7 - Bits 7 to 2 of every high-byte register read as zero.
// R8 - Comparator A is a 10-bit read/write value over two regs, reset 0.
// R9 - Comparator P is a 10-bit read/write period over two regs, reset 0.
// R10 - With clear_select set in compare mode, never match_p_flag.
// R11 - Compare mode with A zero and clear_select set wraps at 0x3FF with no match_a_flag.
// R12 - Each count clock compares the whole counter with both values.
`ifndef PTM_MAP_VH
`define PTM_MAP_VH

`define PTM_ADDR_W 8
`define PTM_OFF_CTRL 8'h00
`define PTM_OFF_COUNT_LOW 8'h04
`define PTM_OFF_COUNT_HIGH 8'h08
`define PTM_OFF_MATCH_A_LOW 8'h0C
`define PTM_OFF_MATCH_A_HIGH 8'h10
`define PTM_OFF_PERIOD_LOW 8'h14
`define PTM_OFF_PERIOD_HIGH 8'h18
`define PTM_OFF_STATUS 8'h1C
`define PTM_OFF_CAPTURE_LOW 8'h20
`define PTM_OFF_CAPTURE_HIGH 8'h24

`define PTM_CTRL_RUN 0
`define PTM_CTRL_MODE_LO 1
`define PTM_CTRL_MODE_HI 2
`define PTM_CTRL_CLEAR_SEL 3
`define PTM_CTRL_CAP_SRC 4

`define PTM_STAT_MATCH_A 0
`define PTM_STAT_MATCH_P 1
`define PTM_STAT_CAPTURE 2

`define PTM_MODE_COMPARE 2'h0
`define PTM_MODE_CAPTURE 2'h1
`define PTM_MODE_PWM 2'h2
`define PTM_MODE_TIMER 2'h3

`define PTM_RESET_BYTE 8'h00
`define PTM_RESET_CTRL 5'h00

`endif

// >>> rtl/ptm_timer.v
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "ptm_map.vh"

module ptm_timer #(
  parameter CNT_W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PTM_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire count_tick,
  input wire internal_capture_input,
  input wire external_clock_pin,
  output reg [CNT_W-1:0] count_value,
  output reg match_a_flag,
  output reg match_p_flag,
  output reg capture_flag,
  output reg counter_clear
);

  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam HI_W = CNT_W - 8;

  // one-hot states of the bus slave
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ACCESS = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;

  reg run;
  reg [1:0] mode;
  reg clear_select;
  reg capture_source_sel;
  reg [CNT_W-1:0] comparator_a_value;
  reg [CNT_W-1:0] period_value;
  reg [CNT_W-1:0] capture_value;
  reg trig_prev;

  // address check used by both the write enable and the error answer
  function mapped;
    input [`PTM_ADDR_W-1:0] a;
    begin
      if (a == `PTM_OFF_CTRL)
        mapped = 1'b1;
      else if (a == `PTM_OFF_COUNT_LOW)
        mapped = 1'b1;
      else if (a == `PTM_OFF_COUNT_HIGH)
        mapped = 1'b1;
      else if (a == `PTM_OFF_MATCH_A_LOW)
        mapped = 1'b1;
      else if (a == `PTM_OFF_MATCH_A_HIGH)
        mapped = 1'b1;
      else if (a == `PTM_OFF_PERIOD_LOW)
        mapped = 1'b1;
      else if (a == `PTM_OFF_PERIOD_HIGH)
        mapped = 1'b1;
      else if (a == `PTM_OFF_STATUS)
        mapped = 1'b1;
      else if (a == `PTM_OFF_CAPTURE_LOW)
        mapped = 1'b1;
      else if (a == `PTM_OFF_CAPTURE_HIGH)
        mapped = 1'b1;
      else
        mapped = 1'b0;
    end
  endfunction

  // high-byte view of a 10-bit value, upper bits forced to zero
  function [31:0] high_word;
    input [CNT_W-1:0] v;
    begin
      high_word = {{(32-HI_W){1'b0}}, v[CNT_W-1:8]}; // [R7]
    end
  endfunction

  function [31:0] low_word;
    input [CNT_W-1:0] v;
    begin
      low_word = {24'h0000_00, v[7:0]};
    end
  endfunction

  // ---------------- bus slave ----------------
  wire setup_phase = psel & ~penable;
  wire wr_take = (state == ST_ACCESS) & psel & penable & pwrite & pready;
  wire wr_ok = wr_take & mapped(paddr) & pstrb[0];

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (setup_phase)
          next_state = ST_ACCESS;
      end
      ST_ACCESS: begin
        next_state = ST_DONE;
      end
      ST_DONE: begin
        if (setup_phase)
          next_state = ST_ACCESS;
        else
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h0000_0000;
    if (paddr == `PTM_OFF_CTRL)
      next_rdata = {27'h000_0000, capture_source_sel, clear_select,
                    mode, run};
    else if (paddr == `PTM_OFF_COUNT_LOW)
      next_rdata = low_word(count_value); // [R6]
    else if (paddr == `PTM_OFF_COUNT_HIGH)
      next_rdata = high_word(count_value); // [R6]
    else if (paddr == `PTM_OFF_MATCH_A_LOW)
      next_rdata = low_word(comparator_a_value); // [R8]
    else if (paddr == `PTM_OFF_MATCH_A_HIGH)
      next_rdata = high_word(comparator_a_value); // [R8]
    else if (paddr == `PTM_OFF_PERIOD_LOW)
      next_rdata = low_word(period_value); // [R9]
    else if (paddr == `PTM_OFF_PERIOD_HIGH)
      next_rdata = high_word(period_value); // [R9]
    else if (paddr == `PTM_OFF_STATUS)
      next_rdata = {29'h0000_0000, capture_flag, match_p_flag,
                    match_a_flag};
    else if (paddr == `PTM_OFF_CAPTURE_LOW)
      next_rdata = low_word(capture_value);
    else if (paddr == `PTM_OFF_CAPTURE_HIGH)
      next_rdata = high_word(capture_value);
  end

  // one wait-free access: pready rises in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      pready <= setup_phase;
      if (setup_phase) begin
        pslverr <= ~mapped(paddr);
        if (!pwrite)
          prdata <= next_rdata;
        else
          prdata <= 32'h0000_0000;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------- configuration ----------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      mode <= `PTM_MODE_COMPARE;
      clear_select <= 1'b0;
      capture_source_sel <= 1'b0;
      comparator_a_value <= CNT_ZERO;
      period_value <= CNT_ZERO;
    end else if (clk_en && wr_ok) begin
      if (paddr == `PTM_OFF_CTRL) begin
        run <= pwdata[`PTM_CTRL_RUN];
        mode <= pwdata[`PTM_CTRL_MODE_HI:`PTM_CTRL_MODE_LO];
        clear_select <= pwdata[`PTM_CTRL_CLEAR_SEL];
        capture_source_sel <= pwdata[`PTM_CTRL_CAP_SRC];
      end else if (paddr == `PTM_OFF_MATCH_A_LOW)
        comparator_a_value[7:0] <= pwdata[7:0]; // [R8]
      else if (paddr == `PTM_OFF_MATCH_A_HIGH)
        comparator_a_value[CNT_W-1:8] <= pwdata[HI_W-1:0]; // [R8]
      else if (paddr == `PTM_OFF_PERIOD_LOW)
        period_value[7:0] <= pwdata[7:0]; // [R9]
      else if (paddr == `PTM_OFF_PERIOD_HIGH)
        period_value[CNT_W-1:8] <= pwdata[HI_W-1:0]; // [R9]
    end
  end

  // ---------------- counter core ----------------
  wire compare_like = (mode == `PTM_MODE_COMPARE) |
                      (mode == `PTM_MODE_TIMER);
  // clear_select only matters in compare match and timer modes
  wire use_a_clear = compare_like & clear_select; // [R5]
  wire period_zero = (period_value == CNT_ZERO);
  wire a_zero = (comparator_a_value == CNT_ZERO);
  wire step = run & count_tick;

  // both comparators see the whole counter on each count clock
  wire hit_a = (count_value == comparator_a_value); // [R12]
  wire hit_p = (count_value == period_value); // [R12]
  wire at_max = (count_value == CNT_MAX);

  reg clear_now;
  reg ev_a;
  reg ev_p;

  always @* begin
    clear_now = 1'b0;
    ev_a = 1'b0;
    ev_p = 1'b0;
    if (step) begin
      if (use_a_clear) begin
        // a zero comparator A lets the counter wrap at its top
        clear_now = a_zero ? at_max : hit_a; // [R2] [R11]
        ev_a = hit_a & ~a_zero; // [R10] [R11]
      end else begin
        if (period_zero)
          clear_now = at_max; // [R3] [R4]
        else
          clear_now = hit_p; // [R3] [R4]
        ev_p = period_zero ? at_max : hit_p;
        if (compare_like)
          ev_a = hit_a & ~a_zero; // [R11]
        else
          ev_a = hit_a;
      end
    end
  end

  // ---------------- capture trigger ----------------
  wire trig = capture_source_sel ? external_clock_pin
                                 : internal_capture_input; // [R1]
  wire trig_rise = trig & ~trig_prev;
  wire cap_now = run & (mode == `PTM_MODE_CAPTURE) & trig_rise;

  // status clears are write-one; a new event in the same cycle wins
  wire st_wr = wr_ok & (paddr == `PTM_OFF_STATUS);
  wire clr_a = st_wr & pwdata[`PTM_STAT_MATCH_A];
  wire clr_p = st_wr & pwdata[`PTM_STAT_MATCH_P];
  wire clr_c = st_wr & pwdata[`PTM_STAT_CAPTURE];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= CNT_ZERO;
      capture_value <= CNT_ZERO;
      trig_prev <= 1'b0;
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
      capture_flag <= 1'b0;
      counter_clear <= 1'b0;
    end else if (clk_en) begin
      trig_prev <= trig;
      counter_clear <= clear_now;
      if (clear_now)
        count_value <= CNT_ZERO; // [R2] [R3]
      else if (step)
        count_value <= count_value + {{(CNT_W-1){1'b0}}, 1'b1};
      if (cap_now)
        capture_value <= count_value; // [R1]
      if (ev_a)
        match_a_flag <= 1'b1;
      else if (clr_a)
        match_a_flag <= 1'b0;
      if (ev_p)
        match_p_flag <= 1'b1; // [R10]
      else if (clr_p)
        match_p_flag <= 1'b0;
      if (cap_now)
        capture_flag <= 1'b1;
      else if (clr_c)
        capture_flag <= 1'b0;
    end
  end

endmodule

// >>> test/ptm_timer_chk.sv
`timescale 1ns/1ps
`include "ptm_map.vh"
module ptm_timer_chk #(
  parameter CNT_W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PTM_ADDR_W-1:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire [CNT_W-1:0] count_value,
  input wire match_a_flag,
  input wire match_p_flag,
  input wire capture_flag,
  input wire counter_clear
);
  wire [7:0] cnt_lo = count_value[7:0];
  wire [1:0] cnt_hi = count_value[9:8];
  wire rd_ok = pready && !pwrite;
  wire hi_addr = (paddr == `PTM_OFF_COUNT_HIGH) ||
    (paddr == `PTM_OFF_MATCH_A_HIGH) || (paddr == `PTM_OFF_PERIOD_HIGH);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_a: assert property (psel && !penable && clk_en |=> pready)
    else $error("setup not answered");
  high_zero_a: assert property (rd_ok && hi_addr
    |-> prdata[31:2] == 30'h0) else $error("high byte upper bits set");
  count_lo_rd_a: assert property (rd_ok && paddr == `PTM_OFF_COUNT_LOW
    |-> prdata == {24'h00_0000, $past(cnt_lo)}) else $error("count low bad");
  count_hi_rd_a: assert property (rd_ok && paddr == `PTM_OFF_COUNT_HIGH
    |-> prdata[1:0] == $past(cnt_hi)) else $error("count high bad");
  count_step_a: assert property (count_value != $past(count_value)
    |-> count_value == $past(count_value) + 10'd1 || count_value == 10'd0)
    else $error("counter jumped");
  clear_pulse_a: assert property (count_value == 10'd0 &&
    $past(count_value) != 10'd0 && $past(count_value) != 10'h3FF
    |-> counter_clear) else $error("clear not signalled");
  clear_cause_a: assert property (counter_clear
    |-> count_value == 10'd0) else $error("clear without zero");
  p_flag_zero_a: assert property ($rose(match_p_flag)
    |-> count_value == 10'd0) else $error("p flag without clear");
  wrap_zero_a: assert property ($past(count_value) == 10'h3FF &&
    count_value != 10'h3FF |-> count_value == 10'd0) else $error("bad wrap");
  flag_hold_a: assert property ($fell(match_a_flag) ||
    $fell(match_p_flag) || $fell(capture_flag) |-> $past(psel) &&
    $past(pwrite) && $past(paddr) == `PTM_OFF_STATUS)
    else $error("flag lost");
  clr_c: cover property (counter_clear);
  cap_c: cover property ($rose(capture_flag));
  a_c: cover property ($rose(match_a_flag));
endmodule
bind ptm_timer ptm_timer_chk #(.CNT_W(CNT_W)) i_chk (.pclk, .presetn,
  .clk_en, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
  .count_value, .match_a_flag, .match_p_flag, .capture_flag, .counter_clear);

// >>> test/ptm_timer_tb.sv
`timescale 1ns/1ps
`include "ptm_map.vh"
module ptm_timer_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic count_tick = 0, internal_capture_input = 0, external_clock_pin = 0;
  logic clk_en = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  wire pready, pslverr, match_a_flag, match_p_flag, capture_flag;
  wire counter_clear;
  wire [31:0] prdata;
  wire [9:0] count_value;
  int fail_count = 0, num_checks = 0;
  always #50 pclk = ~pclk;
  ptm_timer i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .count_tick,
    .internal_capture_input, .external_clock_pin, .count_value,
    .match_a_flag, .match_p_flag, .capture_flag, .counter_clear);
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      complete_run;
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hF, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask
  task tick(input int n);
    count_tick <= 1'b1;
    repeat (n) @(posedge pclk);
    count_tick <= 1'b0;
    @(posedge pclk);
  endtask
  task pulse(input logic ext);
    if (ext) external_clock_pin <= 1'b1;
    else internal_capture_input <= 1'b1;
    repeat (2) @(posedge pclk);
    external_clock_pin <= 1'b0;
    internal_capture_input <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task do_reset;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // run bit is written last so counting starts from a clean zero
  task cfg(input logic [9:0] a, input logic [9:0] p, input logic [4:0] c);
    do_reset;
    w(`PTM_OFF_MATCH_A_LOW, {24'h0, a[7:0]});
    w(`PTM_OFF_MATCH_A_HIGH, {30'h0, a[9:8]});
    w(`PTM_OFF_PERIOD_LOW, {24'h0, p[7:0]});
    w(`PTM_OFF_PERIOD_HIGH, {30'h0, p[9:8]});
    w(`PTM_OFF_CTRL, {27'h0, c});
  endtask
  task flags(input logic a, input logic p);
    chk("match_a_flag", {31'h0, a}, {31'h0, match_a_flag});
    chk("match_p_flag", {31'h0, p}, {31'h0, match_p_flag});
  endtask
  initial begin
    do_reset;
    for (int i = 1; i < 7; i++)
      rchk(8'(i * 4), 32'h0, 1'b0);
    $display("test reset_values done");
    w(`PTM_OFF_MATCH_A_LOW, 32'h0000_00A5);
    w(`PTM_OFF_MATCH_A_HIGH, 32'hFFFF_FFFF);
    w(`PTM_OFF_PERIOD_LOW, 32'h0000_005A);
    w(`PTM_OFF_PERIOD_HIGH, 32'h0000_00FE);
    w(`PTM_OFF_COUNT_LOW, 32'h0000_0077);
    rchk(`PTM_OFF_MATCH_A_LOW, 32'h0000_00A5, 1'b0);
    rchk(`PTM_OFF_MATCH_A_HIGH, 32'h0000_0003, 1'b0);
    rchk(`PTM_OFF_PERIOD_LOW, 32'h0000_005A, 1'b0);
    rchk(`PTM_OFF_PERIOD_HIGH, 32'h0000_0002, 1'b0);
    rchk(`PTM_OFF_COUNT_LOW, 32'h0000_0000, 1'b0);
    rchk(8'h30, 32'h0000_0000, 1'b1);
    $display("test register_access done");
    cfg(10'h3A5, 10'd5, 5'b00001);
    tick(8);
    chk("count_value", 32'd2, {22'h0, count_value});
    flags(1'b0, 1'b1);
    rchk(`PTM_OFF_COUNT_LOW, 32'd2, 1'b0);
    clk_en <= 1'b0;
    tick(3);
    clk_en <= 1'b1;
    chk("count_value", 32'd2, {22'h0, count_value});
    $display("test period_clear done");
    cfg(10'd3, 10'd1, 5'b01001);
    tick(6);
    chk("count_value", 32'd2, {22'h0, count_value});
    flags(1'b1, 1'b0);
    $display("test match_a_clear done");
    cfg(10'h200, 10'd0, 5'b00001);
    tick(1023);
    chk("count_value", 32'h3FF, {22'h0, count_value});
    chk("match_p_flag", 32'h0, {31'h0, match_p_flag});
    rchk(`PTM_OFF_COUNT_HIGH, 32'h0000_0003, 1'b0);
    tick(1);
    chk("count_value", 32'h0, {22'h0, count_value});
    chk("match_p_flag", 32'h1, {31'h0, match_p_flag});
    $display("test overflow_clear done");
    cfg(10'd0, 10'd0, 5'b01001);
    tick(1024);
    chk("count_value", 32'h0, {22'h0, count_value});
    flags(1'b0, 1'b0);
    $display("test zero_compare done");
    cfg(10'd5, 10'd2, 5'b01101);
    tick(4);
    chk("count_value", 32'd1, {22'h0, count_value});
    chk("match_p_flag", 32'h1, {31'h0, match_p_flag});
    $display("test pwm_ignores_select done");
    cfg(10'd0, 10'd0, 5'b00011);
    tick(3);
    pulse(1'b1);
    chk("capture_flag", 32'h0, {31'h0, capture_flag});
    pulse(1'b0);
    chk("capture_flag", 32'h1, {31'h0, capture_flag});
    rchk(`PTM_OFF_CAPTURE_LOW, 32'd3, 1'b0);
    w(`PTM_OFF_CTRL, 32'h0000_0013);
    w(`PTM_OFF_STATUS, 32'h0000_0007);
    pulse(1'b0);
    chk("capture_flag", 32'h0, {31'h0, capture_flag});
    pulse(1'b1);
    chk("capture_flag", 32'h1, {31'h0, capture_flag});
    $display("test capture_source done");
    complete_run;
  end
endmodule
